/* File: src/patch_pkg.sv */
// Constants and types shared by the fetch address patch trap block
package patch_pkg;

	// Full instruction address width of the processor
	localparam int ADDR_W = 24;
	// Number of independent detection address slots
	localparam int SLOT_N = 2;
	localparam int SLOT_IDX_W = 1;

	// Control register field positions
	localparam int CTRL_W = 2;
	localparam int CTRL_EN0_BIT = 0;
	localparam int CTRL_EN1_BIT = 1;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
	localparam logic [ADDR_W-1:0] SLOT_RESET = 24'h000000;
	localparam logic [ADDR_W-1:0] LATCH_RESET = 24'h000000;

	// Software interrupt substituted for the matching instruction
	localparam int VEC_W = 8;
	localparam logic [VEC_W-1:0] TRAP_VECTOR_NUM = 8'h09;
	localparam logic [VEC_W-1:0] VECTOR_RESET = 8'h00;

	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [CTRL_W-1:0] ctrl_t;

endpackage : patch_pkg

/* File: src/patch_slot_regs.sv */
// Two-entry store of detection addresses with registered outputs
`timescale 1ns/1ps
module patch_slot_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [patch_pkg::SLOT_N-1:0] we,
	input wire patch_pkg::addr_t wdata,
	output patch_pkg::addr_t q0,
	output patch_pkg::addr_t q1
);

	patch_pkg::addr_t mem_reg [patch_pkg::SLOT_N];

	genvar g;
	generate
		for (g = 0; g < patch_pkg::SLOT_N; g++) begin : g_slot
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					mem_reg[g] <= patch_pkg::SLOT_RESET;
				end else if (we[g]) begin
					mem_reg[g] <= wdata;
				end
			end
		end
	endgenerate

	// Entries are flops, so both read ports come straight from registers
	assign q0 = mem_reg[0];
	assign q1 = mem_reg[1];

endmodule : patch_slot_regs

/* File: src/fetch_address_patch_trap.sv */
// Next-instruction address comparator that forces a vector 9 trap
// Notes on behaviour
// - Latch next-instruction address every instruction
// - Compare latch against slots continuously
// - Enabled match forces vector 9 trap
// - Two writable detection address slots
// - Disabled slot match produces no trap
// - Control register enables match interrupts
`timescale 1ns/1ps
module fetch_address_patch_trap (
	input wire logic CLK,
	input wire logic RST_N,
	input wire patch_pkg::addr_t NEXT_ADDR,
	input wire logic NEXT_ADDR_VALID,
	input wire patch_pkg::addr_t WR_DATA,
	input wire logic SLOT0_WE,
	input wire logic SLOT1_WE,
	input wire logic CTRL_WE,
	output patch_pkg::addr_t SLOT0_ADDR,
	output patch_pkg::addr_t SLOT1_ADDR,
	output patch_pkg::ctrl_t CTRL_STATE,
	output patch_pkg::addr_t LATCHED_ADDR,
	output logic [patch_pkg::SLOT_N-1:0] MATCH_HIT,
	output logic TRAP_REQ,
	output logic [patch_pkg::VEC_W-1:0] TRAP_VECTOR
);

	// Full-width equality; partial compares would alias other code
	function automatic logic addr_hit(input patch_pkg::addr_t a,
		input patch_pkg::addr_t b);
		addr_hit = (a == b);
	endfunction : addr_hit

	patch_pkg::addr_t latch_reg;
	patch_pkg::addr_t latch_next;
	logic latch_ok_reg;
	patch_pkg::ctrl_t ctrl_reg;
	patch_pkg::ctrl_t ctrl_next;
	logic [patch_pkg::SLOT_N-1:0] hit_reg;
	logic trap_reg;
	logic [patch_pkg::VEC_W-1:0] vec_reg;
	patch_pkg::addr_t slot0_q;
	patch_pkg::addr_t slot1_q;
	logic [patch_pkg::SLOT_N-1:0] slot_we;
	logic [patch_pkg::SLOT_N-1:0] raw_hit;
	logic [patch_pkg::SLOT_N-1:0] slot_en;
	logic [patch_pkg::SLOT_N-1:0] hit_next;
	logic trap_next;
	logic [patch_pkg::VEC_W-1:0] vec_next;

	assign slot_we = {SLOT1_WE, SLOT0_WE};

	patch_slot_regs u_slots (
		.clk(CLK),
		.rst_n(RST_N),
		.we(slot_we),
		.wdata(WR_DATA),
		.q0(slot0_q),
		.q1(slot1_q)
	);

	// Address latch follows every instruction boundary
	assign latch_next = NEXT_ADDR_VALID ? NEXT_ADDR : latch_reg;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			latch_reg <= patch_pkg::LATCH_RESET;
			latch_ok_reg <= 1'b0;
		end else begin
			latch_reg <= latch_next;
			latch_ok_reg <= latch_ok_reg | NEXT_ADDR_VALID;
		end
	end

	// Control register: one enable per slot
	assign ctrl_next = CTRL_WE ? WR_DATA[patch_pkg::CTRL_W-1:0] : ctrl_reg;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_reg <= patch_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign slot_en[0] = ctrl_reg[patch_pkg::CTRL_EN0_BIT];
	assign slot_en[1] = ctrl_reg[patch_pkg::CTRL_EN1_BIT];

	// No fetch seen since reset means the latch holds no real address
	assign raw_hit[0] = latch_ok_reg & addr_hit(latch_reg, slot0_q);
	assign raw_hit[1] = latch_ok_reg & addr_hit(latch_reg, slot1_q);
	assign hit_next = raw_hit & slot_en;
	assign trap_next = |hit_next;
	assign vec_next = trap_next ? patch_pkg::TRAP_VECTOR_NUM
		: patch_pkg::VECTOR_RESET;

	// Recomputed every cycle, so a slot or enable change shows on the outputs one cycle after it lands
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			hit_reg <= '0;
			trap_reg <= 1'b0;
			vec_reg <= patch_pkg::VECTOR_RESET;
		end else begin
			hit_reg <= hit_next;
			trap_reg <= trap_next;
			vec_reg <= vec_next;
		end
	end

	assign SLOT0_ADDR = slot0_q;
	assign SLOT1_ADDR = slot1_q;
	assign CTRL_STATE = ctrl_reg;
	assign LATCHED_ADDR = latch_reg;
	assign MATCH_HIT = hit_reg;
	assign TRAP_REQ = trap_reg;
	assign TRAP_VECTOR = vec_reg;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_fetch;
		NEXT_ADDR_VALID;
	endsequence

	sequence s_armed0;
		latch_ok_reg && ctrl_reg[patch_pkg::CTRL_EN0_BIT]
			&& (latch_reg == slot0_q);
	endsequence

	sequence s_armed1;
		latch_ok_reg && ctrl_reg[patch_pkg::CTRL_EN1_BIT]
			&& (latch_reg == slot1_q);
	endsequence

	property p_latch_capture;
		s_fetch |=> (LATCHED_ADDR == $past(NEXT_ADDR));
	endproperty

	AST_LATCH_CAPTURE: assert property (p_latch_capture)
		else $error("Address latch missed a next-instruction address");

	AST_LATCH_HOLD: assert property (
		!NEXT_ADDR_VALID |=> $stable(LATCHED_ADDR))
		else $error("Address latch changed with no fetch");

	AST_SLOT0_TRAP: assert property (s_armed0 |=> TRAP_REQ && MATCH_HIT[0])
		else $error("Enabled slot 0 match gave no trap");

	AST_SLOT1_TRAP: assert property (s_armed1 |=> TRAP_REQ && MATCH_HIT[1])
		else $error("Enabled slot 1 match gave no trap");

	AST_FETCH_TO_TRAP: assert property (
		s_fetch ##1 s_armed0 |=> TRAP_VECTOR == patch_pkg::TRAP_VECTOR_NUM)
		else $error("Matching fetch did not raise vector 9 two cycles on");

	AST_FETCH_TO_TRAP1: assert property (
		s_fetch ##1 s_armed1 |=> TRAP_VECTOR == patch_pkg::TRAP_VECTOR_NUM)
		else $error("Slot 1 fetch match did not raise vector 9");

	AST_DISABLED_QUIET: assert property (
		(ctrl_reg == 2'h0) |=> !TRAP_REQ && (MATCH_HIT == 2'h0))
		else $error("Trap raised with both slots disabled");

	AST_CTRL_WRITE: assert property (
		CTRL_WE |=> CTRL_STATE == $past(WR_DATA[1:0]))
		else $error("Control write not taken");

	AST_SLOT_WRITE: assert property (
		SLOT0_WE |=> SLOT0_ADDR == $past(WR_DATA))
		else $error("Slot 0 write not taken");

	AST_TRAP_CAUSE: assert property (
		TRAP_REQ |-> ($past(latch_reg) == $past(slot0_q)
			&& $past(ctrl_reg[0]))
			|| ($past(latch_reg) == $past(slot1_q) && $past(ctrl_reg[1])))
		else $error("Trap raised without a full-width enabled match");

	AST_NO_EARLY_TRAP: assert property (
		!latch_ok_reg |=> !TRAP_REQ)
		else $error("Trap raised before any address was latched");

	AST_SLOT1_WRITE: assert property (
		SLOT1_WE |=> SLOT1_ADDR == $past(WR_DATA))
		else $error("Slot 1 write not taken");

	// A stray change of a slot would patch code nobody asked for
	AST_SLOT0_HOLD: assert property (
		!SLOT0_WE |=> $stable(SLOT0_ADDR))
		else $error("Slot 0 changed with no write");

	AST_SLOT1_HOLD: assert property (
		!SLOT1_WE |=> $stable(SLOT1_ADDR))
		else $error("Slot 1 changed with no write");

	AST_CTRL_HOLD: assert property (
		!CTRL_WE |=> $stable(CTRL_STATE))
		else $error("Control changed with no write");

	// Per-slot quiet checks catch a hit leaking from the other slot
	AST_SLOT0_QUIET: assert property (
		!(latch_ok_reg && ctrl_reg[patch_pkg::CTRL_EN0_BIT]
			&& (latch_reg == slot0_q)) |=> !MATCH_HIT[0])
		else $error("Slot 0 hit without an enabled match");

	AST_SLOT1_QUIET: assert property (
		!(latch_ok_reg && ctrl_reg[patch_pkg::CTRL_EN1_BIT]
			&& (latch_reg == slot1_q)) |=> !MATCH_HIT[1])
		else $error("Slot 1 hit without an enabled match");

	AST_VECTOR_PAIR: assert property (
		TRAP_VECTOR == (TRAP_REQ ? patch_pkg::TRAP_VECTOR_NUM
			: patch_pkg::VECTOR_RESET))
		else $error("Trap vector does not follow the trap request");

	AST_TRAP_FROM_HIT: assert property (
		TRAP_REQ == (MATCH_HIT != 2'h0))
		else $error("Trap request and slot hits disagree");

	// Enable write lands at +1, registered compare shows it at +2
	sequence s_disable_all;
		CTRL_WE && (WR_DATA[patch_pkg::CTRL_W-1:0] == 2'h0);
	endsequence

	AST_DISABLE_SILENCES: assert property (
		s_disable_all |=> ##1 !TRAP_REQ)
		else $error("Trap still raised after both enables were cleared");

endmodule : fetch_address_patch_trap

/* File: bench/fetch_seq_model.sv */
// Instruction sequencer model issuing next-instruction addresses
`timescale 1ns/1ps
module fetch_seq_model (
	input wire logic clk,
	output patch_pkg::addr_t next_addr,
	output logic next_valid
);
	patch_pkg::addr_t last;
	initial begin
		next_addr = 24'h000000;
		next_valid = 1'b0;
		last = 24'h000000;
	end
	// Idle bus shows the inverse, so a stale address never looks valid
	task automatic fetch(input patch_pkg::addr_t a, b, input bit two);
		@(posedge clk);
		next_addr <= a;
		next_valid <= 1'b1;
		last = b;
		if (two) begin
			@(posedge clk);
			next_addr <= b;
		end
		@(posedge clk);
		next_addr <= ~last;
		next_valid <= 1'b0;
	endtask : fetch
endmodule : fetch_seq_model

/* File: bench/fetch_address_patch_trap_tb.sv */
// Self-checking bench for the fetch address patch trap
`timescale 1ns/1ps
module fetch_address_patch_trap_tb;
	typedef struct {
		patch_pkg::addr_t s0, s1, a;
		patch_pkg::ctrl_t en;
		logic [1:0] hit;
	} row_t;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic SLOT0_WE = 1'b0, SLOT1_WE = 1'b0, CTRL_WE = 1'b0, NEXT_ADDR_VALID;
	logic TRAP_REQ;
	logic [1:0] MATCH_HIT;
	logic [7:0] TRAP_VECTOR;
	patch_pkg::ctrl_t CTRL_STATE;
	patch_pkg::addr_t WR_DATA = 24'h000000;
	patch_pkg::addr_t NEXT_ADDR, SLOT0_ADDR, SLOT1_ADDR, LATCHED_ADDR;
	int err_count = 0;
	int n_tests = 0;
	row_t rows [6] = '{
		'{24'h123456, 24'habcdef, 24'h123456, 2'h1, 2'h1},
		'{24'h123456, 24'habcdef, 24'h123456, 2'h0, 2'h0},
		'{24'h123456, 24'habcdef, 24'habcdef, 2'h2, 2'h2},
		'{24'h123456, 24'habcdef, 24'h123457, 2'h3, 2'h0},
		'{24'h123456, 24'habcdef, 24'h923456, 2'h3, 2'h0},
		'{24'h555555, 24'h555555, 24'h555555, 2'h3, 2'h3}};
	always #12.5 CLK = ~CLK;
	fetch_seq_model SEQ (.clk(CLK), .next_addr(NEXT_ADDR),
		.next_valid(NEXT_ADDR_VALID));
	fetch_address_patch_trap DUT (.CLK(CLK), .RST_N(RST_N),
		.NEXT_ADDR(NEXT_ADDR), .NEXT_ADDR_VALID(NEXT_ADDR_VALID),
		.WR_DATA(WR_DATA), .SLOT0_WE(SLOT0_WE), .SLOT1_WE(SLOT1_WE),
		.CTRL_WE(CTRL_WE), .SLOT0_ADDR(SLOT0_ADDR), .SLOT1_ADDR(SLOT1_ADDR),
		.CTRL_STATE(CTRL_STATE), .LATCHED_ADDR(LATCHED_ADDR),
		.MATCH_HIT(MATCH_HIT), .TRAP_REQ(TRAP_REQ),
		.TRAP_VECTOR(TRAP_VECTOR));
	task automatic chk(input string nm, input logic [23:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Holds the strobe up; caller drops it one edge later
	task automatic wr(input logic [2:0] we, input patch_pkg::addr_t d);
		@(posedge CLK);
		{CTRL_WE, SLOT1_WE, SLOT0_WE} <= we;
		WR_DATA <= d;
	endtask : wr
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		#1;
		chk("trap_rst", {TRAP_VECTOR, MATCH_HIT, TRAP_REQ}, 24'h0);
		chk("latch_rst", LATCHED_ADDR, 24'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(3'b100, 24'h000000);
			wr(3'b001, rows[i].s0);
			wr(3'b010, rows[i].s1);
			wr(3'b100, {22'h0, rows[i].en});
			@(posedge CLK);
			{CTRL_WE, SLOT1_WE, SLOT0_WE} <= 3'h0;
			SEQ.fetch(rows[i].a, rows[i].a, 1'b0);
			@(posedge CLK);
			#1;
			chk("slot0", SLOT0_ADDR, rows[i].s0);
			chk("slot1", SLOT1_ADDR, rows[i].s1);
			chk("ctrl", CTRL_STATE, rows[i].en);
			chk("latch", LATCHED_ADDR, rows[i].a);
			chk("hit", MATCH_HIT, rows[i].hit);
			chk("trap", TRAP_REQ, |rows[i].hit);
			chk("vec", TRAP_VECTOR, (|rows[i].hit) ? 8'h09 : 8'h00);
			$display("test row %0d done", i);
		end
		SEQ.fetch(24'h555555, 24'h555554, 1'b1);
		#1;
		chk("b2b_first", TRAP_REQ, 1'b1);
		@(posedge CLK);
		#1;
		chk("b2b_second", TRAP_REQ, 1'b0);
		chk("b2b_latch", LATCHED_ADDR, 24'h555554);
		$display("test back to back done");
		SEQ.fetch(24'h555555, 24'h555555, 1'b0);
		RST_N <= 1'b0;
		@(posedge CLK);
		#1;
		chk("mid_trap", {MATCH_HIT, TRAP_VECTOR, TRAP_REQ}, 24'h0);
		chk("mid_ctrl", CTRL_STATE, 24'h0);
		chk("mid_slot0", SLOT0_ADDR, 24'h0);
		chk("mid_slot1", SLOT1_ADDR, 24'h0);
		chk("mid_latch", LATCHED_ADDR, 24'h0);
		$display("test mid reset done");
		// Slots and latch both reset to 0: only a real fetch may hit
		@(posedge CLK);
		RST_N <= 1'b1;
		wr(3'b100, 24'h000003);
		@(posedge CLK);
		{CTRL_WE, SLOT1_WE, SLOT0_WE} <= 3'h0;
		repeat (2) @(posedge CLK);
		#1;
		chk("no_early", TRAP_REQ, 1'b0);
		SEQ.fetch(24'h000000, 24'h000000, 1'b0);
		@(posedge CLK);
		#1;
		chk("first_fetch", TRAP_REQ, 1'b1);
		chk("first_hit", MATCH_HIT, 2'h3);
		$display("test reset release done");
		give_verdict();
	end
endmodule : fetch_address_patch_trap_tb
